// [shared/ivs_pkg.sv]
package ivs_pkg;

  // ************************************************************
  // Table geometry
  // ************************************************************

  // Program addresses are 24 bits wide; each table entry is one 2-address word.
  localparam int ADDR_W = 24;
  localparam int VEC_W = 7;
  localparam int LEVEL_W = 3;
  localparam int TRAP_ENTRIES = 8;
  localparam int TRAP_SOURCES = 4;
  localparam int IRQ_ENTRIES = 118;
  localparam int TABLE_ENTRIES = 126;
  // Oscillator fail sits one entry after the reserved word at the table base.
  localparam logic [VEC_W-1:0] TRAP_FIRST_ENTRY = 7'h01;
  localparam logic [VEC_W-1:0] IRQ_FIRST_ENTRY = 7'h08;
  localparam logic [ADDR_W-1:0] PRIMARY_BASE = 24'h000004;
  localparam logic [ADDR_W-1:0] ALT_OFFSET = 24'h000100;
  localparam logic [ADDR_W-1:0] ALTERNATE_BASE = 24'h000104;
  localparam logic [ADDR_W-1:0] RESET_PC = 24'h000000;
  localparam logic [ADDR_W-1:0] GOTO_TARGET_ADDR = 24'h000002;
  localparam logic [ADDR_W-1:0] CODE_START = 24'h000200;

  // Interrupt entries that have a real source; all others are reserved.
  localparam logic [IRQ_ENTRIES-1:0] IRQ_IMPLEMENTED =
    {1'b0, 7'h7f, 4'h0, 3'h7, 5'h00, 4'hf, 28'h0000000, 1'b1, 7'h00,
     1'b1, 27'h0000000, 1'b1, 8'h00, 5'h1f, 2'h0, 9'h1ff, 1'b0, 4'hf};

  // ************************************************************
  // Program image held by the core end
  // ************************************************************

  localparam int MEM_WORDS = 256;
  localparam int MEM_IDX_W = 8;
  localparam logic [MEM_IDX_W-1:0] ALT_WORD_OFFSET = 8'h80;
  localparam logic [MEM_IDX_W-1:0] GOTO_TARGET_WORD = 8'h01;
  // Jump opcode word placed at the reset location; value is arbitrary.
  localparam logic [ADDR_W-1:0] JUMP_OPCODE = 24'h040000;

  // ************************************************************
  // Selector states
  // ************************************************************

  typedef enum logic [2:0]
  {
    SEL_IDLE = 3'b001,
    SEL_READ = 3'b010,
    SEL_LOAD = 3'b100
  } ivs_state_type;

endpackage

// [shared/ivs_link_if.sv]
interface ivs_link_if;

  // Table entry read: selector asks, core answers one cycle later.
  logic rd_req;
  logic [ivs_pkg::ADDR_W-1:0] rd_addr;
  logic rd_valid;
  logic [ivs_pkg::ADDR_W-1:0] rd_data;
  // Handler address to load into the program counter.
  logic pc_load;
  logic [ivs_pkg::ADDR_W-1:0] pc_value;

  modport selector
  (
    output rd_req,
    output rd_addr,
    input rd_valid,
    input rd_data,
    output pc_load,
    output pc_value
  );

  modport core
  (
    input rd_req,
    input rd_addr,
    output rd_valid,
    output rd_data,
    input pc_load,
    input pc_value
  );

endinterface

// [hw/ivs_selector.sv]
// Functional notes
// (R1) Primary table starts at word 000004h.
// (R2) 126 entries: 8 traps, 118 interrupts.
// (R3) Entry is 24-bit handler address for PC.
// (R4) Lower table address means higher priority.
// (R5) 35 interrupts, 4 traps; rest reserved.
// (R6) Select bit chooses alternate or primary table.
// (R7) Alternate table mirrors layout, 0x100 higher.
// (R8) Traps: osc, address, stack, math, reserved.
// (R9) Reset fetches no vector table entry.
// (R10) Reset clears state, PC restarts at zero.
// (R11) Image holds jump, target at 0x000002.
// (R12) Unused entries point to default handler.
// (R13) Unused alternate table copies primary entries.
// (R14) Application code starts at 0x000200.
// (R15) Equal levels resolve by table position.
// (R16) Fetch address is base plus twice index.
module ivs_selector
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Link to the core end.
  ivs_link_if.selector link,
  // Exception sources, held high until taken.
  input wire logic [ivs_pkg::TRAP_SOURCES-1:0] trap_req,
  input wire logic [ivs_pkg::IRQ_ENTRIES-1:0] irq_req,
  input wire logic [ivs_pkg::IRQ_ENTRIES-1:0][ivs_pkg::LEVEL_W-1:0] irq_level,
  // Processor state and table choice.
  input wire logic [ivs_pkg::LEVEL_W-1:0] cpu_level,
  input wire logic alt_table_select,
  // Report of the vector that was taken.
  output logic taken,
  output logic taken_is_trap,
  output logic [ivs_pkg::VEC_W-1:0] taken_entry,
  output logic busy
);

  // ************************************************************
  // Declarations
  // ************************************************************

  ivs_pkg::ivs_state_type state;
  ivs_pkg::ivs_state_type next_state;
  logic trap_found;
  logic [1:0] trap_best;
  logic irq_found;
  logic [ivs_pkg::VEC_W-1:0] irq_best;
  logic [ivs_pkg::LEVEL_W-1:0] lvl_best;
  logic [ivs_pkg::VEC_W-1:0] next_entry;
  logic next_is_trap;
  logic [ivs_pkg::ADDR_W-1:0] next_addr;
  logic [ivs_pkg::ADDR_W-1:0] table_base;
  logic [ivs_pkg::VEC_W-1:0] entry;
  logic entry_is_trap;

  // ************************************************************
  // Source selection
  // ************************************************************

  // Lowest trap number wins, so oscillator fail outranks the others.
  always_comb
  begin
    trap_found = 1'b0;
    trap_best = 2'h0;
    for (int i = ivs_pkg::TRAP_SOURCES - 1; i >= 0; i--)
    begin
      if (trap_req[i])
      begin
        trap_found = 1'b1; // R8
        trap_best = 2'(i); // R4
      end
    end
  end

  // Highest user level above the processor level wins.  Only a strictly
  // greater level replaces the current pick, so on a tie the lower entry
  // keeps it.  Reserved entries are never looked at.
  always_comb
  begin
    irq_found = 1'b0;
    irq_best = 7'h00;
    lvl_best = cpu_level;
    for (int i = 0; i < ivs_pkg::IRQ_ENTRIES; i++)
    begin
      if (ivs_pkg::IRQ_IMPLEMENTED[i] && irq_req[i] && irq_level[i] > lvl_best) // R5
      begin
        irq_found = 1'b1;
        irq_best = 7'(i); // R15
        lvl_best = irq_level[i];
      end
    end
  end

  // Traps sit below every interrupt entry and are not maskable, so they
  // always come first.  Entries are numbered across the whole table.
  always_comb
  begin
    next_is_trap = trap_found;
    if (trap_found)
    begin
      next_entry = ivs_pkg::TRAP_FIRST_ENTRY + {5'h00, trap_best}; // R4
    end
    else
    begin
      next_entry = ivs_pkg::IRQ_FIRST_ENTRY + irq_best; // R2
    end
  end

  // ************************************************************
  // Fetch address
  // ************************************************************

  // One bit swaps the whole table; both share one layout, so only the base moves.
  assign table_base = alt_table_select ? ivs_pkg::ALTERNATE_BASE
                                       : ivs_pkg::PRIMARY_BASE; // R6 R7 R1
  // Each entry is one word, two program addresses apart.
  assign next_addr = table_base + {16'h0000, next_entry, 1'b0}; // R16

  // ************************************************************
  // Sequencer
  // ************************************************************

  // A request is only chosen in idle; the choice is frozen until the
  // handler address has been handed over, so a later, higher source waits.
  always_comb
  begin
    next_state = state;
    case (state)
      ivs_pkg::SEL_IDLE:
      begin
        if (trap_found || irq_found)
        begin
          next_state = ivs_pkg::SEL_READ;
        end
      end
      ivs_pkg::SEL_READ:
      begin
        if (link.rd_valid)
        begin
          next_state = ivs_pkg::SEL_LOAD;
        end
      end
      ivs_pkg::SEL_LOAD:
      begin
        next_state = ivs_pkg::SEL_IDLE;
      end
      default:
      begin
        next_state = ivs_pkg::SEL_IDLE;
      end
    endcase
  end

  // Reset just parks the sequencer; no table entry is read for it.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state <= ivs_pkg::SEL_IDLE; // R9
    end
    else
    begin
      state <= next_state;
    end
  end

  // Latch the chosen entry and its table address on leaving idle.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      entry <= 7'h00;
      entry_is_trap <= 1'b0;
      link.rd_addr <= ivs_pkg::RESET_PC;
    end
    else if (state == ivs_pkg::SEL_IDLE && (trap_found || irq_found))
    begin
      entry <= next_entry;
      entry_is_trap <= next_is_trap;
      link.rd_addr <= next_addr; // R16
    end
  end

  // The read request is a single pulse; the core answers once.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      link.rd_req <= 1'b0;
    end
    else
    begin
      link.rd_req <= state == ivs_pkg::SEL_IDLE && (trap_found || irq_found);
    end
  end

  // ************************************************************
  // Program counter hand-over
  // ************************************************************

  // The word read back is the handler start address, passed on unchanged.
  // After reset the value offered is zero, where execution begins.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      link.pc_load <= 1'b0;
      link.pc_value <= ivs_pkg::RESET_PC; // R10
    end
    else
    begin
      link.pc_load <= state == ivs_pkg::SEL_READ && link.rd_valid; // R3
      if (state == ivs_pkg::SEL_READ && link.rd_valid)
      begin
        link.pc_value <= link.rd_data; // R3
      end
    end
  end

  // The taken report rides with the load pulse so sources can clear.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      taken <= 1'b0;
      taken_is_trap <= 1'b0;
      taken_entry <= 7'h00;
    end
    else
    begin
      taken <= state == ivs_pkg::SEL_READ && link.rd_valid;
      if (state == ivs_pkg::SEL_READ && link.rd_valid)
      begin
        taken_is_trap <= entry_is_trap;
        taken_entry <= entry;
      end
    end
  end

  // Busy covers the whole read and load so the user sees one window.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      busy <= 1'b0;
    end
    else
    begin
      busy <= next_state != ivs_pkg::SEL_IDLE;
    end
  end

endmodule

// [hw/ivs_core.sv]
module ivs_core
#(
  parameter logic [23:0] DEFAULT_HANDLER = 24'h000200,
  parameter logic [23:0] STARTUP_ADDR = 24'h000200
)
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Link to the selector.
  ivs_link_if.core link,
  // Program image loading.
  input wire logic img_wr,
  input wire logic [ivs_pkg::ADDR_W-1:0] img_addr,
  input wire logic [ivs_pkg::ADDR_W-1:0] img_data,
  input wire logic img_mirror,
  output logic img_err,
  // Program counter.
  output logic [ivs_pkg::ADDR_W-1:0] pc
);

  // ************************************************************
  // Table image
  // ************************************************************

  logic [ivs_pkg::ADDR_W-1:0] mem [ivs_pkg::MEM_WORDS];
  logic [ivs_pkg::MEM_IDX_W-1:0] wr_idx;
  logic wr_ok;
  logic wr_primary;

  assign wr_idx = img_addr[ivs_pkg::MEM_IDX_W:1];
  // Only the table region below the start of code may be written.
  assign wr_ok = img_addr < ivs_pkg::CODE_START; // R14
  // Only primary table words mirror; the reserved words after the table would
  // land past the alternate table and wrap onto the reset words.
  assign wr_primary = img_addr >= ivs_pkg::PRIMARY_BASE &&
                      img_addr < ivs_pkg::PRIMARY_BASE + 24'(2 * ivs_pkg::TABLE_ENTRIES);

  // Reset fills every entry with the default handler, then plants the jump.
  // This costs a wide reset, but no entry can ever point at garbage.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      for (int w = 0; w < ivs_pkg::MEM_WORDS; w++)
      begin
        mem[w] <= DEFAULT_HANDLER; // R12
      end
      mem[0] <= ivs_pkg::JUMP_OPCODE; // R11
      mem[ivs_pkg::GOTO_TARGET_WORD] <= STARTUP_ADDR; // R11
    end
    else if (img_wr && wr_ok)
    begin
      mem[wr_idx] <= img_data;
      if (img_mirror && wr_primary)
      begin
        mem[wr_idx + ivs_pkg::ALT_WORD_OFFSET] <= img_data; // R13
      end
    end
  end

  // A refused write is flagged for one cycle.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      img_err <= 1'b0;
    end
    else
    begin
      img_err <= img_wr && !wr_ok;
    end
  end

  // ************************************************************
  // Link answers
  // ************************************************************

  // Table reads answer on the next edge.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      link.rd_valid <= 1'b0;
      link.rd_data <= ivs_pkg::RESET_PC;
    end
    else
    begin
      link.rd_valid <= link.rd_req;
      if (link.rd_req)
      begin
        link.rd_data <= mem[link.rd_addr[ivs_pkg::MEM_IDX_W:1]];
      end
    end
  end

  // The program counter restarts at zero and takes each handler address.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pc <= ivs_pkg::RESET_PC;
    end
    else if (link.pc_load)
    begin
      pc <= link.pc_value;
    end
  end

endmodule

// [dv/ivs_link_checker.sv]
module ivs_link_checker
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Link between selector and core.
  input wire logic rd_req,
  input wire logic [ivs_pkg::ADDR_W-1:0] rd_addr,
  input wire logic rd_valid,
  input wire logic [ivs_pkg::ADDR_W-1:0] rd_data,
  input wire logic pc_load,
  input wire logic [ivs_pkg::ADDR_W-1:0] pc_value
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****
  // Link timing
  // ****

  default clocking cb @(posedge sys_clk); endclocking

  // A read is a single pulse that the core answers on the next cycle.
  a_read_answered: assert property (disable iff (reset) rd_req |=> rd_valid && !rd_req)
    else $error("table read not answered");
  a_load_follows: assert property (disable iff (reset) rd_valid |=> pc_load ##1 !pc_load)
    else $error("handler load missing");
  a_load_word: assert property (disable iff (reset)
    pc_load |-> pc_value == $past(rd_data) && $past(rd_req, 2))
    else $error("loaded value is not the table word");
  // Every fetch lands on an even address inside one of the two tables.
  a_addr_range: assert property (disable iff (reset)
    rd_req |-> rd_addr >= 24'h000006 && rd_addr <= 24'h0001fe && !rd_addr[0] &&
      !(rd_addr >= 24'h000100 && rd_addr <= 24'h000104))
    else $error("fetch address outside the tables");
  a_addr_hold: assert property (disable iff (reset) !rd_req ##1 !rd_req |-> $stable(rd_addr))
    else $error("fetch address moved without a read");
  a_pick_spacing: assert property (disable iff (reset) pc_load |=> !rd_req)
    else $error("new fetch too soon after load");
  a_pc_hold: assert property (disable iff (reset) !pc_load |-> $stable(pc_value))
    else $error("handler address moved without load");
  // Reset clears the link and fetches nothing.
  a_reset_clears: assert property (reset |=> !rd_req && !pc_load && pc_value == 24'h000000)
    else $error("link not cleared by reset");

  // Main scenarios.
  c_alt_fetch: cover property (disable iff (reset) rd_req && rd_addr >= 24'h000114);
  c_trap_fetch: cover property (disable iff (reset) rd_req && rd_addr < 24'h000014);
  c_load: cover property (disable iff (reset) pc_load);
endmodule

// [dv/interrupt_vector_selector_tb.sv]
module interrupt_vector_selector_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****
  // Stimulus and observed signals
  // ****

  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] trap_req = 4'h0;
  logic [117:0] irq_req = '0;
  logic [117:0][2:0] irq_level = {118{3'h1}};
  logic [2:0] cpu_level = 3'h0;
  logic alt_table_select = 1'b0;
  logic img_wr = 1'b0;
  logic [23:0] img_addr = 24'h000000;
  logic [23:0] img_data = 24'h000000;
  logic img_mirror = 1'b0;
  logic taken;
  logic taken_is_trap;
  logic [6:0] taken_entry;
  logic busy;
  logic img_err;
  logic [23:0] pc;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  ivs_link_if ivs_link_if_inst ();

  ivs_selector ivs_selector_inst (.sys_clk(sys_clk), .reset(reset), .link(ivs_link_if_inst),
    .trap_req(trap_req), .irq_req(irq_req), .irq_level(irq_level), .cpu_level(cpu_level),
    .alt_table_select(alt_table_select), .taken(taken), .taken_is_trap(taken_is_trap),
    .taken_entry(taken_entry), .busy(busy));

  ivs_core ivs_core_inst (.sys_clk(sys_clk), .reset(reset), .link(ivs_link_if_inst),
    .img_wr(img_wr), .img_addr(img_addr), .img_data(img_data), .img_mirror(img_mirror),
    .img_err(img_err), .pc(pc));

  ivs_link_checker ivs_link_checker_inst (.sys_clk(sys_clk), .reset(reset),
    .rd_req(ivs_link_if_inst.rd_req), .rd_addr(ivs_link_if_inst.rd_addr),
    .rd_valid(ivs_link_if_inst.rd_valid), .rd_data(ivs_link_if_inst.rd_data),
    .pc_load(ivs_link_if_inst.pc_load), .pc_value(ivs_link_if_inst.pc_value));

  // ****
  // Shared tasks
  // ****

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic img_write(input logic [23:0] a, input logic [23:0] d, input logic m,
                           output logic err);
    @(posedge sys_clk);
    img_wr <= 1'b1;
    img_addr <= a;
    img_data <= d;
    img_mirror <= m;
    @(posedge sys_clk);
    img_wr <= 1'b0;
    #1;
    err = img_err;
  endtask

  // Sources are dropped on the edge after taken, so the same one is not taken twice.
  task automatic pick(input logic [3:0] t, input logic [117:0] q, input logic alt,
                      input logic [6:0] e, input logic [23:0] a, input logic [23:0] d);
    int n;
    @(posedge sys_clk);
    trap_req <= t;
    irq_req <= q;
    alt_table_select <= alt;
    n = 0;
    while (taken !== 1'b1 && n < 10)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("taken", 24'(taken), 24'h000001);
    chk("taken_is_trap", 24'(taken_is_trap), 24'(t != 4'h0));
    chk("busy in load", 24'(busy), 24'h000001);
    chk("entry", 24'(taken_entry), 24'(e));
    chk("fetch address", ivs_link_if_inst.rd_addr, a);
    chk("pc_value", ivs_link_if_inst.pc_value, d);
    @(posedge sys_clk);
    trap_req <= 4'h0;
    irq_req <= '0;
    #1;
    chk("pc", pc, d);
    chk("busy after load", 24'(busy), 24'h000000);
  endtask

  // ****
  // Clock and timeout
  // ****

  // Free running 200 MHz clock.
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // A hang ends the run as a failure rather than running forever.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  // ****
  // Scenarios
  // ****

  // Holds a request that must not start a fetch and watches busy for 8 cycles.
  task automatic hold_idle(input logic [117:0] q, input logic [2:0] lvl, output logic seen);
    @(posedge sys_clk);
    irq_req <= q;
    cpu_level <= lvl;
    seen = 1'b0;
    repeat (8)
    begin
      @(posedge sys_clk);
      #1;
      seen = seen | busy;
    end
    @(posedge sys_clk);
    irq_req <= '0;
    cpu_level <= 3'h0;
  endtask

  // Traps and two interrupts get distinct handlers, mirrored into the alternate table.
  // A mirrored write to the reserved words between the tables must not wrap onto
  // the reset words, and the code area refuses writes.
  task automatic scn_image_load();
    logic e;
    for (int i = 1; i <= 4; i++)
    begin
      img_write(24'(4 + 2 * i), 24'(24'h000300 + i), 1'b1, e);
    end
    img_write(24'h000014, 24'h000400, 1'b1, e);
    img_write(24'h00001a, 24'h000403, 1'b1, e);
    img_write(24'h000114, 24'h000500, 1'b0, e);
    chk("img_err low", 24'(e), 24'h000000);
    img_write(24'h000100, 24'h000777, 1'b1, e);
    chk("goto opcode", ivs_core_inst.mem[0], ivs_pkg::JUMP_OPCODE);
    chk("goto target", ivs_core_inst.mem[1], 24'h000200);
    img_write(24'h000200, 24'h000001, 1'b0, e);
    chk("img_err code area", 24'(e), 24'h000001);
  endtask

  // Each trap alone, with an interrupt pending that must lose, then two at once.
  task automatic scn_traps();
    for (int i = 0; i < 4; i++)
    begin
      pick(4'(1 << i), 118'h1, 1'b0, 7'(i + 1), 24'(6 + 2 * i), 24'(24'h000301 + i));
    end
    pick(4'hc, '0, 1'b1, 7'h03, 24'h00010a, 24'h000303);
  endtask

  // Equal levels go by position; a higher level beats a lower entry.
  task automatic scn_interrupts();
    pick(4'h0, 118'h9, 1'b0, 7'h08, 24'h000014, 24'h000400);
    pick(4'h0, 118'h9, 1'b1, 7'h08, 24'h000114, 24'h000500);
    @(posedge sys_clk);
    irq_level[3] <= 3'h5;
    pick(4'h0, 118'h9, 1'b0, 7'h0b, 24'h00001a, 24'h000403);
  endtask

  // A reserved entry, and an interrupt not above the processor level, never fetch.
  task automatic scn_no_fetch();
    logic e;
    hold_idle(118'h10, 3'h0, e);
    chk("reserved busy", 24'(e), 24'h000000);
    hold_idle(118'h08, 3'h5, e);
    chk("masked busy", 24'(e), 24'h000000);
  endtask

  // Reset in mid-run clears the link; an entry never written still fetches the default handler.
  task automatic scn_mid_reset();
    @(posedge sys_clk);
    irq_req <= '0;
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    chk("pc after reset", pc, 24'h000000);
    chk("busy after reset", 24'(busy), 24'h000000);
    chk("pc_value after reset", ivs_link_if_inst.pc_value, 24'h000000);
    pick(4'h0, 118'h2, 1'b0, 7'h09, 24'h000016, 24'h000200);
  endtask

  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    chk("pc after reset", pc, 24'h000000);
    scn_image_load();
    scn_traps();
    scn_interrupts();
    scn_no_fetch();
    scn_mid_reset();
    print_verdict();
  end
endmodule
